/* File: rtl/i2ccfg_filter.v */
// all-taps-agree noise filter for one bus input, bypassable
`include "i2ccfg_regs.vh"

module i2ccfg_filter
(
   input  wire i_clock,
   input  wire i_rst,
   input  wire i_enable,
   input  wire i_level,
   output wire o_level
);

   reg  [`I2CCFG_FILTER_TAPS-1:0] taps_q;
   reg                            held_q;
   wire                           all_one;
   wire                           all_zero;

   assign all_one  = &taps_q;
   assign all_zero = ~|taps_q;

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         taps_q <= {`I2CCFG_FILTER_TAPS{1'b1}};
         held_q <= 1'b1;
      end
      else
      begin
         taps_q <= {taps_q[`I2CCFG_FILTER_TAPS-2:0], i_level};
         if (all_one)
            held_q <= 1'b1;
         else if (all_zero)
            held_q <= 1'b0;
      end
   end

   // fixed tap delay only; the scl width counters run regardless of filtering
   assign o_level = i_enable ? held_q : i_level;

endmodule // i2ccfg_filter

/* File: rtl/i2ccfg_regs.vh */
// register offsets, field positions, reset values and timing counts
`ifndef I2CCFG_REGS_VH
`define I2CCFG_REGS_VH

`define I2CCFG_ADDR_W            16
`define I2CCFG_OFF_PORT6_DIR     16'hff26
`define I2CCFG_OFF_PORT6_IBSEL   16'hff3e
`define I2CCFG_OFF_BUS_CTL_TWO   16'hffa8
`define I2CCFG_OFF_BUS_FLAG      16'hffa9
`define I2CCFG_OFF_SCL_LOW_W     16'hffa4
`define I2CCFG_OFF_SCL_HIGH_W    16'hffa5
`define I2CCFG_OFF_PORT6_OMODE   16'hff0e

`define I2CCFG_RST_PORT6_DIR     8'hff
`define I2CCFG_RST_PORT6_IBSEL   8'h00
`define I2CCFG_RST_BUS_CTL_TWO   8'h00
`define I2CCFG_RST_BUS_FLAG      8'h00
`define I2CCFG_RST_SCL_W         8'hff
`define I2CCFG_RST_PORT6_OMODE   8'h00

`define I2CCFG_BIT_WAKEUP        7
`define I2CCFG_BIT_CLK_LEVEL     5
`define I2CCFG_BIT_DATA_LEVEL    4
`define I2CCFG_BIT_SPEED         3
`define I2CCFG_BIT_FILTER        2
`define I2CCFG_BIT_BUSY          6
`define I2CCFG_BIT_INIT_START    1
`define I2CCFG_BIT_RSV_DIS       0
`define I2CCFG_BIT_PIN_SCL       0
`define I2CCFG_BIT_PIN_SDA       1

`define I2CCFG_CTL_TWO_RW_MASK   8'h8c
`define I2CCFG_FLAG_RW_MASK      8'h03
`define I2CCFG_IBSEL_MASK        8'h03
`define I2CCFG_DIR_MASK          8'h0f
`define I2CCFG_DIR_FIXED         8'hf0
`define I2CCFG_OMODE_MASK        8'h0f

`define I2CCFG_FILTER_TAPS       3

`endif

/* File: rtl/i2ccfg_top.v */
// configuration and status registers of the i2c controller, with pin control
`include "i2ccfg_regs.vh"

module i2ccfg_top
(
   input  wire                      i_clock,
   input  wire                      i_rst,
   input  wire [`I2CCFG_ADDR_W-1:0] i_addr,
   input  wire                      i_wr,
   input  wire                      i_rd,
   input  wire [7:0]                i_wdata,
   output reg  [7:0]                o_rdata,
   input  wire                      i_operation_enable,
   input  wire                      i_start_detect,
   input  wire                      i_stop_detect,
   input  wire                      i_master_status_flag,
   input  wire                      i_extension_code_flag,
   input  wire                      i_address_match_flag,
   input  wire                      i_start_detected_flag,
   input  wire                      i_stop_interrupt_enable,
   input  wire                      i_stop_irq_req,
   input  wire                      i_match_irq_req,
   input  wire                      i_bus_irq_src,
   input  wire                      i_scl_out,
   input  wire                      i_sda_out,
   input  wire                      i_scl_drive,
   input  wire                      i_port_latch_scl,
   input  wire                      i_port_latch_sda,
   input  wire                      i_bus_clock_pin,
   input  wire                      i_bus_data_pin,
   output wire                      o_bus_clock_pin,
   output wire                      o_bus_clock_pin_oe_n,
   output wire                      o_bus_data_pin,
   output wire                      o_bus_data_pin_oe_n,
   output wire                      o_scl_level,
   output wire                      o_sda_level,
   output wire                      o_bus_interrupt,
   output wire                      o_wakeup_request,
   output wire                      o_bus_busy_flag,
   output wire                      o_reservation_disable,
   output wire                      o_fast_mode,
   output wire                      o_smbus_scl,
   output wire                      o_smbus_sda,
   output wire                      o_master_blocked,
   output wire                      o_scl_phase_done
);

   ////////////////////////////////////////////////////////////////////////
   // register decode

   function automatic hit;
      input [`I2CCFG_ADDR_W-1:0] a;
      input [`I2CCFG_ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   wire wr_ctl  = i_wr & hit(i_addr, `I2CCFG_OFF_BUS_CTL_TWO);
   wire wr_flag = i_wr & hit(i_addr, `I2CCFG_OFF_BUS_FLAG);
   wire wr_wl   = i_wr & hit(i_addr, `I2CCFG_OFF_SCL_LOW_W);
   wire wr_wh   = i_wr & hit(i_addr, `I2CCFG_OFF_SCL_HIGH_W);
   wire wr_ib   = i_wr & hit(i_addr, `I2CCFG_OFF_PORT6_IBSEL);
   wire wr_om   = i_wr & hit(i_addr, `I2CCFG_OFF_PORT6_OMODE);
   wire wr_dir  = i_wr & hit(i_addr, `I2CCFG_OFF_PORT6_DIR);
   // speed, filter, option and scl width writes honoured only while stopped; protects a running transfer
   wire stopped = ~i_operation_enable;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and level flags

   reg  [1:0] scl_sync_q;
   reg  [1:0] sda_sync_q;
   wire       scl_filt;
   wire       sda_filt;
   reg        clk_level_q;
   reg        data_level_q;

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         scl_sync_q <= 2'h3;
         sda_sync_q <= 2'h3;
      end
      else
      begin
         scl_sync_q <= {scl_sync_q[0], i_bus_clock_pin};
         sda_sync_q <= {sda_sync_q[0], i_bus_data_pin};
      end
   end

   reg ctl_filter_q;
   reg ctl_speed_q;
   wire filter_on = ctl_filter_q & ctl_speed_q;

   i2ccfg_filter u_scl_filt
   (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_enable (filter_on),
      .i_level  (scl_sync_q[1]),
      .o_level  (scl_filt)
   );

   i2ccfg_filter u_sda_filt
   (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_enable (filter_on),
      .i_level  (sda_sync_q[1]),
      .o_level  (sda_filt)
   );

   assign o_scl_level = scl_filt;
   assign o_sda_level = sda_filt;

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         clk_level_q  <= 1'b0;
         data_level_q <= 1'b0;
      end
      else
      begin
         clk_level_q  <= i_operation_enable & scl_sync_q[1];
         data_level_q <= i_operation_enable & sda_sync_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register two and flag register

   reg       wakeup_q;
   reg       rsv_dis_q;
   reg       init_start_q;
   reg       busy_q;
   reg       op_en_q;
   reg       blocked_q;
   reg [7:0] wl_q;
   reg [7:0] wh_q;
   reg [7:0] ibsel_q;
   reg [7:0] omode_q;
   reg [7:0] dir_q;

   wire flags_idle = ~(i_master_status_flag | i_extension_code_flag |
                       i_address_match_flag | i_start_detected_flag);
   wire wake_set   = wr_ctl & i_wdata[`I2CCFG_BIT_WAKEUP] & flags_idle;
   wire wake_clr   = wr_ctl & ~i_wdata[`I2CCFG_BIT_WAKEUP];

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         wakeup_q     <= 1'b0;
         ctl_speed_q  <= 1'b0;
         ctl_filter_q <= 1'b0;
         rsv_dis_q    <= 1'b0;
         init_start_q <= 1'b0;
         busy_q       <= 1'b0;
         op_en_q      <= 1'b0;
         blocked_q    <= 1'b0;
      end
      else
      begin
         op_en_q <= i_operation_enable;
         if (wake_set)
            wakeup_q <= 1'b1;
         else if (wake_clr)
            wakeup_q <= 1'b0;
         if (wr_ctl & stopped)
         begin
            ctl_speed_q  <= i_wdata[`I2CCFG_BIT_SPEED];
            ctl_filter_q <= i_wdata[`I2CCFG_BIT_FILTER];
         end
         if (wr_flag & stopped)
            rsv_dis_q <= i_wdata[`I2CCFG_BIT_RSV_DIS];
         // start detection while enabled clears the initial-start option; a write does not override it
         if (i_operation_enable & i_start_detect)
            init_start_q <= 1'b0;
         else if (wr_flag & stopped)
            init_start_q <= i_wdata[`I2CCFG_BIT_INIT_START];
         // busy: start sets, stop or disable clears; set wins over stop, disable wins over set
         if (~i_operation_enable)
            busy_q <= 1'b0;
         else if (i_start_detect)
            busy_q <= 1'b1;
         else if (~op_en_q)
            busy_q <= ~init_start_q;
         else if (i_stop_detect)
            busy_q <= 1'b0;
         // wakeup cleared without a bus interrupt pending blocks master use
         if (wakeup_q & wake_clr & ~i_bus_irq_src)
            blocked_q <= 1'b1;
         else if (i_start_detect | i_stop_detect)
            blocked_q <= 1'b0;
      end
   end

   assign o_bus_busy_flag       = busy_q;
   assign o_reservation_disable = rsv_dis_q;
   assign o_fast_mode           = ctl_speed_q;
   assign o_master_blocked      = blocked_q;
   assign o_wakeup_request      = wakeup_q & i_match_irq_req;
   // match interrupt passes with equal timing; stop interrupt gated in wakeup
   assign o_bus_interrupt = i_match_irq_req |
                            (i_stop_irq_req & i_stop_interrupt_enable & ~wakeup_q);

   ////////////////////////////////////////////////////////////////////////
   // scl width registers and counter

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         wl_q <= `I2CCFG_RST_SCL_W;
         wh_q <= `I2CCFG_RST_SCL_W;
      end
      else
      begin
         if (wr_wl & stopped)
            wl_q <= i_wdata;
         if (wr_wh & stopped)
            wh_q <= i_wdata;
      end
   end

   // one count per peripheral clock; phase length = register value cycles
   reg  [7:0] width_cnt_q;
   reg        scl_drv_q;
   wire [7:0] width_sel = i_scl_out ? wh_q : wl_q;
   // a fresh level counts as cycle one at once, else each phase runs one cycle longer
   wire       phase_new = (scl_drv_q != i_scl_out);
   wire [7:0] width_cur = phase_new ? 8'h01 : width_cnt_q;
   wire       phase_end = (width_cur >= width_sel);

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         width_cnt_q <= 8'h00;
         scl_drv_q   <= 1'b0;
      end
      else
      begin
         scl_drv_q <= i_scl_out;
         if (~i_scl_drive | phase_end)
            width_cnt_q <= 8'h01;
         else
            width_cnt_q <= width_cur + 8'h01;
      end
   end

   assign o_scl_phase_done = i_scl_drive & phase_end;

   ////////////////////////////////////////////////////////////////////////
   // port registers and pin drivers

   always @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         ibsel_q <= `I2CCFG_RST_PORT6_IBSEL;
         omode_q <= `I2CCFG_RST_PORT6_OMODE;
         dir_q   <= `I2CCFG_RST_PORT6_DIR;
      end
      else
      begin
         if (wr_ib)
            ibsel_q <= i_wdata & `I2CCFG_IBSEL_MASK;
         if (wr_om)
            omode_q <= i_wdata & `I2CCFG_OMODE_MASK;
         if (wr_dir)
            dir_q <= (i_wdata & `I2CCFG_DIR_MASK) | `I2CCFG_DIR_FIXED;
      end
   end

   assign o_smbus_scl = ibsel_q[`I2CCFG_BIT_PIN_SCL];
   assign o_smbus_sda = ibsel_q[`I2CCFG_BIT_PIN_SDA];

   // disabled interface forces low onto the pins, hence enable before output
   wire scl_val = i_operation_enable & i_scl_out & i_port_latch_scl;
   wire sda_val = i_operation_enable & i_sda_out & i_port_latch_sda;
   wire scl_out_mode = ~dir_q[`I2CCFG_BIT_PIN_SCL];
   wire sda_out_mode = ~dir_q[`I2CCFG_BIT_PIN_SDA];

   // open-drain: drive only low; push-pull: drive both levels
   assign o_bus_clock_pin = scl_val;
   assign o_bus_data_pin  = sda_val;
   assign o_bus_clock_pin_oe_n = ~(scl_out_mode &
                                   (~omode_q[`I2CCFG_BIT_PIN_SCL] | ~scl_val));
   assign o_bus_data_pin_oe_n  = ~(sda_out_mode &
                                   (~omode_q[`I2CCFG_BIT_PIN_SDA] | ~sda_val));

   ////////////////////////////////////////////////////////////////////////
   // read mux

   always @*
   begin
      o_rdata = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            `I2CCFG_OFF_BUS_CTL_TWO:
               o_rdata = {wakeup_q, 1'b0, clk_level_q, data_level_q,
                          ctl_speed_q, ctl_filter_q, 2'b00};
            `I2CCFG_OFF_BUS_FLAG:
               o_rdata = {1'b0, busy_q, 4'h0, init_start_q, rsv_dis_q};
            `I2CCFG_OFF_SCL_LOW_W:  o_rdata = wl_q;
            `I2CCFG_OFF_SCL_HIGH_W: o_rdata = wh_q;
            `I2CCFG_OFF_PORT6_IBSEL: o_rdata = ibsel_q;
            `I2CCFG_OFF_PORT6_OMODE: o_rdata = omode_q;
            `I2CCFG_OFF_PORT6_DIR:   o_rdata = dir_q;
            default: o_rdata = 8'h00;
         endcase
      end
   end

endmodule // i2ccfg_top

/* File: sim/i2ccfg_bus_model.sv */
// far side of the bus: pull-ups, wired-and, a remote clock and a data hold
module i2ccfg_bus_model
(
   input  wire logic i_scl_drv,
   input  wire logic i_scl_oe_n,
   input  wire logic i_sda_drv,
   input  wire logic i_sda_oe_n,
   input  wire logic i_run,
   input  wire logic i_hold_sda,
   output wire logic o_scl,
   output wire logic o_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_q = 1'b1;
   // odd start offset keeps remote edges off the block clock edges
   initial
   begin
      #1.1;
      forever #62.5 clk_q = i_run ? ~clk_q : 1'b1;
   end
   // released lines float to the pull-up level
   assign o_scl = (i_scl_oe_n | i_scl_drv) & clk_q;
   assign o_sda = (i_sda_oe_n | i_sda_drv) & ~i_hold_sda;
endmodule // i2ccfg_bus_model

/* File: sim/i2ccfg_sva.sv */
// concurrent checks on the ports of the i2c configuration block
`include "i2ccfg_regs.vh"

module i2ccfg_sva
(
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic [15:0] i_addr,
   input wire logic        i_wr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_operation_enable,
   input wire logic        i_start_detect,
   input wire logic        i_stop_detect,
   input wire logic        i_stop_interrupt_enable,
   input wire logic        i_stop_irq_req,
   input wire logic        i_match_irq_req,
   input wire logic        i_bus_clock_pin,
   input wire logic        o_scl_level,
   input wire logic        o_bus_clock_pin,
   input wire logic        o_bus_data_pin,
   input wire logic        o_bus_interrupt,
   input wire logic        o_bus_busy_flag,
   input wire logic        o_reservation_disable,
   input wire logic        o_fast_mode,
   input wire logic        o_master_blocked
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   ////////////////////////////////////////////////////////////////////////////
   sequence s_ctl_write;
      i_wr && i_addr == `I2CCFG_OFF_BUS_CTL_TWO && !i_operation_enable;
   endsequence
   // sync plus filter settle well inside eight cycles
   sequence s_scl_steady;
      (i_operation_enable && $stable(i_bus_clock_pin)) [*8];
   endsequence

   ////////////////////////////////////////////////////////////////////////////
   a_rsv_write_only:
      assert property (!(i_wr && i_addr == `I2CCFG_OFF_BUS_FLAG)
         |=> $stable(o_reservation_disable)) else $error("option bit moved without write");
   a_rsv_locked_on:
      assert property (i_operation_enable |=> $stable(o_reservation_disable))
         else $error("option bit written while enabled");
   a_speed_mode_set:
      assert property (s_ctl_write |=> o_fast_mode == $past(i_wdata[3]))
         else $error("speed bit not taken");
   a_speed_mode_held:
      assert property (i_operation_enable |=> $stable(o_fast_mode))
         else $error("speed bit changed while enabled");
   a_stop_irq_mask:
      assert property (i_stop_irq_req && !i_stop_interrupt_enable && !i_match_irq_req
         |-> !o_bus_interrupt) else $error("masked stop interrupt seen");
   a_match_irq_pass:
      assert property (i_match_irq_req |-> o_bus_interrupt) else $error("match irq lost");
   a_pins_low_off:
      assert property (!i_operation_enable |-> !o_bus_clock_pin && !o_bus_data_pin)
         else $error("pin high while disabled");
   a_busy_on_start:
      assert property (i_operation_enable && $past(i_operation_enable) && i_start_detect
         |=> o_bus_busy_flag) else $error("busy not set by start");
   a_busy_clear_off:
      assert property (!i_operation_enable |=> !o_bus_busy_flag) else $error("busy while off");
   a_scl_follow_pin:
      assert property (s_scl_steady |-> o_scl_level == i_bus_clock_pin)
         else $error("clock level not tracking pin");
   a_blocked_release:
      assert property ((i_start_detect || i_stop_detect)
         && !(i_wr && i_addr == `I2CCFG_OFF_BUS_CTL_TWO) |=> !o_master_blocked)
         else $error("master block not released");
endmodule // i2ccfg_sva

bind i2ccfg_top i2ccfg_sva u_i2ccfg_sva (.*);

/* File: sim/i2ccfg_top_bench.sv */
// self-checking bench for the i2c configuration and status block
`include "i2ccfg_regs.vh"

module i2ccfg_top_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] ad_ct2 = `I2CCFG_OFF_BUS_CTL_TWO;
   localparam logic [15:0] ad_flg = `I2CCFG_OFF_BUS_FLAG;
   logic       i_clock, i_rst, i_wr, i_rd, i_operation_enable, i_start_detect, i_stop_detect;
   logic       i_master_status_flag, i_extension_code_flag, i_address_match_flag;
   logic       i_start_detected_flag, i_stop_interrupt_enable, i_stop_irq_req;
   logic       i_match_irq_req, i_bus_irq_src, i_scl_out, i_sda_out, i_scl_drive;
   logic       i_port_latch_scl, i_port_latch_sda, run, hold_sda;
   logic [15:0] i_addr;
   logic [7:0] i_wdata;
   logic [1:0] r;
   wire  [7:0] o_rdata;
   wire        i_bus_clock_pin, i_bus_data_pin, o_bus_clock_pin, o_bus_clock_pin_oe_n;
   wire        o_bus_data_pin, o_bus_data_pin_oe_n, o_scl_level, o_sda_level, o_bus_interrupt;
   wire        o_wakeup_request, o_bus_busy_flag, o_reservation_disable, o_fast_mode;
   wire        o_smbus_scl, o_smbus_sda, o_master_blocked, o_scl_phase_done;
   int         errors, checked, n4, n9, nh;
   logic [15:0] ra [8] = '{16'hff26, 16'hff3e, ad_ct2, ad_flg, 16'hffa4, 16'hffa5,
                          16'hff0e, 16'hff00};
   logic [7:0] rv [8] = '{8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00};

   i2ccfg_top u_i2ccfg_top (.*);
   i2ccfg_bus_model u_i2ccfg_bus_model (.i_scl_drv(o_bus_clock_pin),
      .i_scl_oe_n(o_bus_clock_pin_oe_n), .i_sda_drv(o_bus_data_pin),
      .i_sda_oe_n(o_bus_data_pin_oe_n), .i_run(run), .i_hold_sda(hold_sda),
      .o_scl(i_bus_clock_pin), .o_sda(i_bus_data_pin));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic rc(input logic [15:0] a, input logic [7:0] e, input string n);
      @(posedge i_clock);
      i_addr <= a;
      i_rd <= 1'b1;
      @(negedge i_clock);
      chk(n, o_rdata, e);
      @(posedge i_clock);
      i_rd <= 1'b0;
   endtask
   // event bits: match irq, stop irq, stop, start
   task automatic ev(input logic [3:0] m);
      @(posedge i_clock);
      {i_match_irq_req, i_stop_irq_req, i_stop_detect, i_start_detect} <= m;
      @(negedge i_clock);
      r = {o_wakeup_request, o_bus_interrupt};
      @(posedge i_clock);
      {i_match_irq_req, i_stop_irq_req, i_stop_detect, i_start_detect} <= 4'h0;
      @(negedge i_clock);
   endtask
   // cycles from a clock level change until that phase is complete
   task automatic meas(input logic lvl, output int n);
      @(posedge i_clock);
      i_scl_out <= ~lvl;
      @(posedge i_clock);
      i_scl_out <= lvl;
      n = 0;
      do
      begin
         @(negedge i_clock);
         n++;
      end
      while (o_scl_phase_done !== 1'b1 && n < 600);
   endtask
   task automatic end_of_test;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end
   initial
   begin
      repeat (20000) @(posedge i_clock);
      errors++;
      end_of_test();
   end
   initial
   begin
      {i_addr, i_wdata, i_wr, i_rd, i_operation_enable, i_start_detect, i_stop_detect,
       i_master_status_flag, i_extension_code_flag, i_address_match_flag,
       i_start_detected_flag, i_stop_interrupt_enable, i_stop_irq_req, i_match_irq_req,
       i_bus_irq_src, i_scl_out, i_sda_out, i_scl_drive, i_port_latch_scl,
       i_port_latch_sda, run, hold_sda} = '0;
      i_rst = 1'b1;
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      for (int k = 0; k < 8; k++)
         rc(ra[k], rv[k], "reset value");
      i_scl_drive <= 1'b1;
      wr(16'hffa4, 8'h04);
      meas(1'b0, n4);
      wr(16'hffa4, 8'h09);
      meas(1'b0, n9);
      wr(16'hffa5, 8'h0c);
      meas(1'b1, nh);
      chk("low width step", 8'(n9 - n4), 8'h05);
      chk("high width", 8'(nh - n9), 8'h03);
      chk("low width", 8'(n4), 8'h04);
      @(posedge i_clock);
      {i_scl_drive, i_scl_out, i_sda_out, i_port_latch_scl, i_port_latch_sda} <= 5'h0f;
      wr(ad_flg, 8'h03);
      rc(ad_flg, 8'h03, "option bits");
      wr(ad_ct2, 8'h0c);
      rc(ad_ct2, 8'h0c, "speed filter");
      chk("fast mode", o_fast_mode, 8'h01);
      wr(16'hff26, 8'hfc);
      wr(16'hff0e, 8'h03);
      chk("pins off", {o_bus_clock_pin, o_bus_data_pin}, 8'h00);
      @(posedge i_clock);
      i_operation_enable <= 1'b1;
      repeat (2) @(posedge i_clock);
      chk("busy first", o_bus_busy_flag, 8'h00);
      chk("open drain", {o_bus_clock_pin, o_bus_clock_pin_oe_n, o_bus_data_pin,
          o_bus_data_pin_oe_n}, 8'h0f);
      wr(16'hff0e, 8'h00);
      @(negedge i_clock);
      chk("push pull", {o_bus_clock_pin_oe_n, o_bus_data_pin_oe_n}, 8'h00);
      wr(ad_flg, 8'h00);
      wr(ad_ct2, 8'h00);
      ev(4'h1);
      chk("busy start", o_bus_busy_flag, 8'h01);
      rc(ad_flg, 8'h41, "flag locked");
      ev(4'h2);
      chk("busy stop", o_bus_busy_flag, 8'h00);
      hold_sda <= 1'b1;
      repeat (6) @(posedge i_clock);
      rc(ad_ct2, 8'h2c, "levels sda low");
      chk("sda level", o_sda_level, 8'h00);
      run <= 1'b1;
      repeat (300) @(posedge i_clock);
      @(negedge i_bus_clock_pin);
      repeat (4) @(posedge i_clock);
      rc(ad_ct2, 8'h0c, "levels scl low");
      repeat (300) @(posedge i_clock);
      run <= 1'b0;
      hold_sda <= 1'b0;
      repeat (40) @(posedge i_clock);
      rc(ad_ct2, 8'h3c, "levels high");
      // one-cycle dip must not pass the filter in fast mode
      hold_sda <= 1'b1;
      @(posedge i_clock);
      hold_sda <= 1'b0;
      repeat (8)
      begin
         @(negedge i_clock);
         chk("filtered glitch", o_sda_level, 8'h01);
      end
      @(posedge i_clock);
      i_operation_enable <= 1'b0;
      i_address_match_flag <= 1'b1;
      repeat (4) @(posedge i_clock);
      rc(ad_ct2, 8'h0c, "levels off");
      wr(ad_ct2, 8'h8c);
      rc(ad_ct2, 8'h0c, "wakeup refused");
      {i_address_match_flag, i_stop_interrupt_enable, i_bus_irq_src} <= 3'b011;
      wr(ad_ct2, 8'h8c);
      rc(ad_ct2, 8'h8c, "wakeup set");
      ev(4'h4);
      chk("stop irq masked", r, 8'h00);
      ev(4'h8);
      chk("match wakeup", r, 8'h03);
      wr(ad_ct2, 8'h0c);
      @(negedge i_clock);
      chk("irq clear", o_master_blocked, 8'h00);
      wr(ad_ct2, 8'h8c);
      i_bus_irq_src <= 1'b0;
      wr(ad_ct2, 8'h0c);
      @(negedge i_clock);
      chk("foreign clear", o_master_blocked, 8'h01);
      ev(4'h4);
      chk("stop irq open", r, 8'h01);
      ev(4'h2);
      chk("block released", o_master_blocked, 8'h00);
      wr(16'hff3e, 8'h03);
      @(negedge i_clock);
      chk("smbus select", {o_smbus_scl, o_smbus_sda}, 8'h03);
      end_of_test();
   end
endmodule // i2ccfg_top_bench
